//--- hw/ncm_mode_ctrl.sv
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ns
// Notes on behaviour
// - network parameter writes are dropped outside configuration mode
// - with DHCP selected and no answer, enter configuration mode after 60 s
// - in normal operation, a three second switch hold arms configuration
// - configuration mode halts normal running, indicator alternates fast
// - host connections are refused throughout configuration mode
// - switch presses are ignored while any host connection is open
// - releasing before three seconds returns to normal operation unchanged
// - while held, indicator alternates slowly, speeds up, steady red at 3 s
// - normal operation shows a steady yellow indicator
// - releasing after steady red enters configuration mode
// - configuration mode lasts until power off or new settings committed
// - a three second hold at power-on restores factory default parameters
// - an early release at power-on keeps settings and boots normally
// - after a defaults restore, boot resumes when the switch is released
// - committed settings cause an automatic reboot using them
// - a mandatory host name is kept and offered in DHCP requests
// - either DHCP or static address, mask, gateway and name server stored
// - current network parameters are readable in normal operation
module ncm_mode_ctrl import ncm_pkg::*; #(
    parameter logic [31:0] HOLD_CYCLES = HOLD_CYCLES_DEF,
    parameter logic [31:0] DHCP_CYCLES = DHCP_CYCLES_DEF,
    parameter logic [31:0] SLOW_HALF = SLOW_HALF_DEF,
    parameter logic [31:0] FAST_HALF = FAST_HALF_DEF
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    // interrupt
    output logic irq,
    // configuration switch pin, high = pressed
    input wire logic cfgSwitch,
    // network stack side
    input wire logic hostsOpen,
    input wire logic dhcpBound,
    output logic dhcpRequest,
    output logic [31:0] dhcpHostName,
    output logic connRefuse,
    output logic normalRun,
    output logic configMode,
    output logic rebootReq,
    // power ready indicator
    output logic powerReadyRed,
    output logic powerReadyYellow
);
    localparam logic [31:0] STAGE1 = HOLD_CYCLES / 32'h0000_0003;
    localparam logic [31:0] STAGE2 = 32'(STAGE1 * 2);

    ncm_state_t state;
    ncm_state_t next_state;
    ncm_led_t ledPattern;
    logic [1:0] ledStage;
    logic swLevel;
    logic swPrev;
    logic swPress;
    logic [2:0] settleCount;
    logic settled;
    logic [31:0] holdCount;
    logic holdDone;
    logic [31:0] dhcpTimer;
    logic dhcpExpired;
    logic [31:0] netIp;
    logic [31:0] netMask;
    logic [31:0] netGateway;
    logic [31:0] netDns;
    logic dhcpSelect;
    logic [31:0] hostName;
    logic inConfig;
    logic paramAddr;
    logic paramWrite;
    logic paramRefused;
    logic nameOk;
    logic commitReq;
    logic restoreNow;
    logic [IRQ_W-1:0] irqStatus;
    logic [IRQ_W-1:0] irqMask;
    logic [IRQ_W-1:0] irqSet;
    logic [IRQ_W-1:0] irqClr;

    if (HOLD_CYCLES < 32'h0000_0008 || DHCP_CYCLES < 32'h0000_0002)
    begin : gBadCounts
        $error("ncm_mode_ctrl: hold or DHCP cycle count too small");
    end

    // switch pin crossing
    ncm_sync #(
        .WIDTH(1)
    ) uSwSync (
        .mclk(mclk),
        .rst(rst),
        .pinIn(cfgSwitch),
        .synced(swLevel)
    );

    // press edge
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            swPrev <= 1'b0;
        else
            swPrev <= swLevel;
    end
    assign swPress = swLevel & ~swPrev;

    // wait for the synchroniser to fill
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            settleCount <= 3'h0;
        else if (!settled)
            settleCount <= settleCount + 3'h1;
    end
    assign settled = (settleCount == SETTLE_CYCLES);

    // hold timer, cleared while released
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            holdCount <= 32'h0000_0000;
        else if (!swLevel || !(state == ST_POHOLD || state == ST_HOLD))
            holdCount <= 32'h0000_0000;
        else if (!holdDone)
            holdCount <= holdCount + 32'h0000_0001;
    end
    assign holdDone = (holdCount == HOLD_CYCLES - 32'h0000_0001);

    // DHCP wait timer, booting with DHCP only
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            dhcpTimer <= 32'h0000_0000;
        else if (state != ST_BOOT || !dhcpSelect)
            dhcpTimer <= 32'h0000_0000;
        else if (!dhcpExpired)
            dhcpTimer <= dhcpTimer + 32'h0000_0001;
    end
    assign dhcpExpired = (dhcpTimer == DHCP_CYCLES - 32'h0000_0001);

    // register access decode
    assign inConfig = (state == ST_CONFIG);
    assign paramAddr = (regAddr == REG_IP) || (regAddr == REG_MASK) ||
        (regAddr == REG_GATEWAY) || (regAddr == REG_DNS) ||
        (regAddr == REG_FLAGS) || (regAddr == REG_HOSTNAME);
    assign nameOk = (regAddr != REG_HOSTNAME) || (regWdata != 32'h0000_0000);
    assign paramWrite = regWrite && paramAddr && inConfig && nameOk;
    assign paramRefused = regWrite && paramAddr && !(inConfig && nameOk);
    assign commitReq = regWrite && (regAddr == REG_COMMIT) &&
        regWdata[COMMIT_BIT] && inConfig;
    assign restoreNow = (state == ST_POHOLD) && swLevel && holdDone;

    // mode sequencing
    always_comb
    begin
        next_state = state;
        case (state)
            ST_POWERON:
            begin
                if (settled)
                    next_state = swLevel ? ST_POHOLD : ST_BOOT;
            end
            ST_POHOLD:
            begin
                if (!swLevel)
                    next_state = ST_BOOT;
                else if (holdDone)
                    next_state = ST_PORESTORE;
            end
            ST_PORESTORE:
            begin
                if (!swLevel)
                    next_state = ST_BOOT;
            end
            ST_BOOT:
            begin
                if (!dhcpSelect || dhcpBound)
                    next_state = ST_NORMAL;
                else if (dhcpExpired)
                    next_state = ST_CONFIG;
            end
            ST_NORMAL:
            begin
                if (swPress && !hostsOpen)
                    next_state = ST_HOLD;
            end
            ST_HOLD:
            begin
                if (!swLevel || hostsOpen)
                    next_state = ST_NORMAL;
                else if (holdDone)
                    next_state = ST_ARMED;
            end
            ST_ARMED:
            begin
                if (!swLevel)
                    next_state = ST_CONFIG;
            end
            ST_CONFIG:
            begin
                if (commitReq)
                    next_state = ST_BOOT;
            end
            default: next_state = ST_POWERON;
        endcase
    end

    // state register
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            state <= ST_POWERON;
        else
            state <= next_state;
    end

    // stored network parameters
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            netIp <= DEF_IP;
            netMask <= DEF_MASK;
            netGateway <= DEF_GATEWAY;
            netDns <= DEF_DNS;
            dhcpSelect <= DEF_DHCP;
            hostName <= DEF_HOSTNAME;
        end
        else if (restoreNow)
        begin
            netIp <= DEF_IP;
            netMask <= DEF_MASK;
            netGateway <= DEF_GATEWAY;
            netDns <= DEF_DNS;
            dhcpSelect <= DEF_DHCP;
            hostName <= DEF_HOSTNAME;
        end
        else if (paramWrite)
        begin
            case (regAddr)
                REG_IP: netIp <= regWdata;
                REG_MASK: netMask <= regWdata;
                REG_GATEWAY: netGateway <= regWdata;
                REG_DNS: netDns <= regWdata;
                REG_FLAGS: dhcpSelect <= regWdata[FLAG_DHCP_BIT];
                REG_HOSTNAME: hostName <= regWdata;
                default: netIp <= netIp;
            endcase
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            regRdata <= 32'h0000_0000;
        else if (!regRead)
            regRdata <= 32'h0000_0000;
        else
        begin
            case (regAddr)
                REG_IP: regRdata <= netIp;
                REG_MASK: regRdata <= netMask;
                REG_GATEWAY: regRdata <= netGateway;
                REG_DNS: regRdata <= netDns;
                REG_FLAGS: regRdata <= 32'(dhcpSelect);
                REG_HOSTNAME: regRdata <= hostName;
                REG_STATUS: regRdata <= 32'({dhcpSelect, hostsOpen,
                    swLevel, 1'b0, state});
                REG_IRQ_STAT: regRdata <= 32'(irqStatus);
                REG_IRQ_MASK: regRdata <= 32'(irqMask);
                default: regRdata <= 32'h0000_0000;
            endcase
        end
    end

    // interrupt events, set beats clear
    always_comb
    begin
        irqSet = '0;
        irqSet[IRQ_CONFIG] = (next_state == ST_CONFIG) && !inConfig;
        irqSet[IRQ_DHCP_TO] = (state == ST_BOOT) &&
            (next_state == ST_CONFIG);
        irqSet[IRQ_DEFAULTS] = restoreNow;
        irqSet[IRQ_COMMIT] = commitReq;
        irqSet[IRQ_REFUSED] = paramRefused;
        irqClr = '0;
        if (regWrite && regAddr == REG_IRQ_STAT)
            irqClr = regWdata[IRQ_W-1:0];
    end

    // sticky status and mask
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            irqStatus <= '0;
            irqMask <= '0;
        end
        else
        begin
            irqStatus <= (irqStatus & ~irqClr) | irqSet;
            if (regWrite && regAddr == REG_IRQ_MASK)
                irqMask <= regWdata[IRQ_W-1:0];
        end
    end

    // interrupt line
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(irqStatus & irqMask);
    end

    // mode outputs from the next state; reboot request from the commit strobe, host name from storage
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            normalRun <= 1'b0;
            configMode <= 1'b0;
            connRefuse <= 1'b1;
            dhcpRequest <= 1'b0;
            rebootReq <= 1'b0;
            dhcpHostName <= DEF_HOSTNAME;
        end
        else
        begin
            normalRun <= (next_state == ST_NORMAL) ||
                (next_state == ST_HOLD) || (next_state == ST_ARMED);
            configMode <= (next_state == ST_CONFIG);
            connRefuse <= (next_state == ST_CONFIG) ||
                (next_state == ST_POWERON) || (next_state == ST_POHOLD) ||
                (next_state == ST_PORESTORE);
            dhcpRequest <= (next_state == ST_BOOT) && dhcpSelect;
            rebootReq <= commitReq;
            dhcpHostName <= hostName;
        end
    end

    // indicator pattern per state
    always_comb
    begin
        ledStage = 2'h0;
        if (holdCount >= STAGE2)
            ledStage = 2'h2;
        else if (holdCount >= STAGE1)
            ledStage = 2'h1;
        case (state)
            ST_POWERON, ST_BOOT: ledPattern = LED_BOOT;
            ST_POHOLD, ST_HOLD: ledPattern = LED_ALT_RAMP;
            ST_PORESTORE, ST_ARMED: ledPattern = LED_RED;
            ST_NORMAL: ledPattern = LED_YELLOW;
            ST_CONFIG: ledPattern = LED_ALT_FAST;
            default: ledPattern = LED_OFF;
        endcase
    end

    // indicator driver
    ncm_led #(
        .SLOW_HALF(SLOW_HALF),
        .FAST_HALF(FAST_HALF)
    ) uLed (
        .mclk(mclk),
        .rst(rst),
        .pattern(ledPattern),
        .stage(ledStage),
        .red(powerReadyRed),
        .yellow(powerReadyYellow)
    );
endmodule : ncm_mode_ctrl

//--- hw/ncm_pkg.sv
package ncm_pkg;
    // clock and times
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1000;
    localparam int unsigned HOLD_TIME_MS = 3000;
    localparam int unsigned DHCP_TIMEOUT_S = 60;
    localparam int unsigned SLOW_HALF_MS = 400;
    localparam int unsigned FAST_HALF_MS = 50;
    // cycle counts, top parameter defaults
    localparam logic [31:0] HOLD_CYCLES_DEF =
        32'(HOLD_TIME_MS * CYCLES_PER_MS);
    localparam logic [31:0] DHCP_CYCLES_DEF = 32'(DHCP_TIMEOUT_S * CLK_HZ);
    localparam logic [31:0] SLOW_HALF_DEF = 32'(SLOW_HALF_MS * CYCLES_PER_MS);
    localparam logic [31:0] FAST_HALF_DEF = 32'(FAST_HALF_MS * CYCLES_PER_MS);
    // settle cycles after reset
    localparam logic [2:0] SETTLE_CYCLES = 3'h4;
    // register byte offsets
    localparam logic [7:0] REG_IP = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [7:0] REG_GATEWAY = 8'h08;
    localparam logic [7:0] REG_DNS = 8'h0C;
    localparam logic [7:0] REG_FLAGS = 8'h10;
    localparam logic [7:0] REG_HOSTNAME = 8'h14;
    localparam logic [7:0] REG_COMMIT = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1C;
    localparam logic [7:0] REG_IRQ_STAT = 8'h20;
    localparam logic [7:0] REG_IRQ_MASK = 8'h24;
    // field positions
    localparam int FLAG_DHCP_BIT = 0;
    localparam int COMMIT_BIT = 0;
    localparam int STAT_SW_BIT = 4;
    localparam int STAT_HOSTS_BIT = 5;
    localparam int STAT_DHCP_BIT = 6;
    localparam int IRQ_CONFIG = 0;
    localparam int IRQ_DHCP_TO = 1;
    localparam int IRQ_DEFAULTS = 2;
    localparam int IRQ_COMMIT = 3;
    localparam int IRQ_REFUSED = 4;
    localparam int IRQ_W = 5;
    // factory defaults, also reset values
    localparam logic [31:0] DEF_IP = 32'h0000_0000;
    localparam logic [31:0] DEF_MASK = 32'h0000_0000;
    localparam logic [31:0] DEF_GATEWAY = 32'h0000_0000;
    localparam logic [31:0] DEF_DNS = 32'h0000_0000;
    localparam logic DEF_DHCP = 1'b1;
    localparam logic [31:0] DEF_HOSTNAME = 32'h0000_0A5C; // arbitrary value
    // operating states
    typedef enum logic [2:0] {
        ST_POWERON, ST_POHOLD, ST_PORESTORE, ST_BOOT,
        ST_NORMAL, ST_HOLD, ST_ARMED, ST_CONFIG
    } ncm_state_t;
    // indicator patterns
    typedef enum logic [2:0] {
        LED_OFF, LED_YELLOW, LED_RED, LED_ALT_FAST, LED_ALT_RAMP, LED_BOOT
    } ncm_led_t;
endpackage : ncm_pkg

//--- hw/ncm_sync.sv
`timescale 1ns/1ns
module ncm_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // pin side and clean side
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] stage1;

    if (WIDTH < 1)
    begin : gBadWidth
        $error("ncm_sync: WIDTH must be at least one");
    end

    // two flops per bit, first read only by second
    for (genvar i = 0; i < WIDTH; i++)
    begin : gBit
        always_ff @(posedge mclk or posedge rst)
        begin
            if (rst)
            begin
                stage1[i] <= 1'b0;
                synced[i] <= 1'b0;
            end
            else
            begin
                stage1[i] <= pinIn[i];
                synced[i] <= stage1[i];
            end
        end
    end
endmodule : ncm_sync

//--- hw/ncm_led.sv
`timescale 1ns/1ns
module ncm_led import ncm_pkg::*; #(
    parameter logic [31:0] SLOW_HALF = SLOW_HALF_DEF,
    parameter logic [31:0] FAST_HALF = FAST_HALF_DEF
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // pattern select
    input wire ncm_led_t pattern,
    input wire logic [1:0] stage,
    // two colour indicator
    output logic red,
    output logic yellow
);
    logic [31:0] halfLen;
    logic [31:0] halfCount;
    logic phase;

    if (SLOW_HALF < 32'h0000_0004 || FAST_HALF < 32'h0000_0001)
    begin : gBadHalf
        $error("ncm_led: blink half periods too short");
    end

    // ramp halves the half period per stage
    always_comb
    begin
        if (pattern == LED_ALT_FAST)
            halfLen = FAST_HALF;
        else
            halfLen = SLOW_HALF >> stage;
    end

    // half period counter, >= for a shrinking length
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            halfCount <= 32'h0000_0000;
            phase <= 1'b0;
        end
        else if (halfCount >= halfLen - 32'h0000_0001)
        begin
            halfCount <= 32'h0000_0000;
            phase <= ~phase;
        end
        else
            halfCount <= halfCount + 32'h0000_0001;
    end

    // colour drive
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            red <= 1'b0;
            yellow <= 1'b0;
        end
        else
        begin
            case (pattern)
                LED_YELLOW: {red, yellow} <= 2'h1;
                LED_RED: {red, yellow} <= 2'h2;
                LED_ALT_FAST, LED_ALT_RAMP: {red, yellow} <= {phase, ~phase};
                LED_BOOT: {red, yellow} <= {1'b0, phase};
                default: {red, yellow} <= 2'h0;
            endcase
        end
    end
endmodule : ncm_led

//--- verification/ncm_mode_ctrl_sva.sv
`timescale 1ns/1ns
module ncm_mode_ctrl_chk import ncm_pkg::*; #(
    parameter logic [31:0] HOLD_CYCLES = HOLD_CYCLES_DEF,
    parameter logic [31:0] DHCP_CYCLES = DHCP_CYCLES_DEF
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    // switch and network side
    input wire logic cfgSwitch,
    input wire logic hostsOpen,
    input wire logic dhcpRequest,
    input wire logic connRefuse,
    input wire logic normalRun,
    input wire logic configMode,
    input wire logic rebootReq,
    input wire logic powerReadyRed,
    input wire logic powerReadyYellow
);
    logic [31:0] holdCnt;
    logic [31:0] lastHold;
    logic [31:0] bootCnt;
    logic spoil;
    logic commitWr;
    // commit write
    assign commitWr = regWrite && regAddr == REG_COMMIT &&
        regWdata[COMMIT_BIT];
    // raw press length, spoiled unless clean
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            holdCnt <= 32'h0;
            lastHold <= 32'h0;
            spoil <= 1'b0;
        end
        else
        begin
            holdCnt <= cfgSwitch ? holdCnt + 32'h1 : 32'h0;
            spoil <= cfgSwitch & (spoil | hostsOpen | ~normalRun);
            if (!cfgSwitch && holdCnt != 32'h0)
                lastHold <= holdCnt;
        end
    end
    // cycles of address request
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            bootCnt <= 32'h0;
        else
            bootCnt <= dhcpRequest ? bootCnt + 32'h1 : 32'h0;
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    property p_refuse;
        configMode |-> connRefuse;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("connections open in config");
    property p_halt;
        configMode |-> !normalRun;
    endproperty
    a_halt: assert property (p_halt)
        else $error("running in config");
    property p_blink;
        configMode[*8] |-> powerReadyRed ^ powerReadyYellow;
    endproperty
    a_blink: assert property (p_blink)
        else $error("config blink wrong");
    property p_yellow;
        (normalRun && !cfgSwitch)[*8] |-> powerReadyYellow && !powerReadyRed;
    endproperty
    a_yellow: assert property (p_yellow)
        else $error("not steady yellow");
    property p_commit;
        configMode && commitWr |=> rebootReq && !configMode;
    endproperty
    a_commit: assert property (p_commit)
        else $error("no reboot");
    property p_stay;
        configMode && !commitWr |=> configMode;
    endproperty
    a_stay: assert property (p_stay)
        else $error("config left");
    property p_arm;
        $rose(configMode) && $past(normalRun) |-> lastHold >= HOLD_CYCLES;
    endproperty
    a_arm: assert property (p_arm)
        else $error("short press armed");
    property p_dhcp;
        $rose(configMode) && $past(dhcpRequest) |->
            bootCnt + 32'h3 >= DHCP_CYCLES && bootCnt <= DHCP_CYCLES + 32'h2;
    endproperty
    a_dhcp: assert property (p_dhcp)
        else $error("timeout length");
    property p_red;
        normalRun && !hostsOpen && !spoil && holdCnt >= HOLD_CYCLES + 32'h8
            |-> powerReadyRed && !powerReadyYellow;
    endproperty
    a_red: assert property (p_red)
        else $error("not steady red");
    c_config: cover property ($rose(configMode));
    c_reboot: cover property (rebootReq);
    c_armed: cover property (normalRun && powerReadyRed && !spoil);
endmodule : ncm_mode_ctrl_chk
bind ncm_mode_ctrl ncm_mode_ctrl_chk #(
    .HOLD_CYCLES(HOLD_CYCLES),
    .DHCP_CYCLES(DHCP_CYCLES)
) chk (
    .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .cfgSwitch(cfgSwitch), .hostsOpen(hostsOpen),
    .dhcpRequest(dhcpRequest), .connRefuse(connRefuse),
    .normalRun(normalRun), .configMode(configMode), .rebootReq(rebootReq),
    .powerReadyRed(powerReadyRed), .powerReadyYellow(powerReadyYellow)
);

//--- verification/ncm_net_model.sv
`timescale 1ns/1ns
module ncm_net_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // bench commands
    input wire logic wantHost,
    input wire logic answerDhcp,
    // device side
    input wire logic connRefuse,
    input wire logic dhcpRequest,
    output logic hostsOpen,
    output logic dhcpBound
);
    // hosts connect if accepted; server answers requests
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            hostsOpen <= 1'b0;
            dhcpBound <= 1'b0;
        end
        else
        begin
            hostsOpen <= wantHost & (hostsOpen | ~connRefuse);
            dhcpBound <= answerDhcp & dhcpRequest;
        end
    end
endmodule : ncm_net_model

//--- verification/network_config_mode_control_tb.sv
`timescale 1ns/1ns
module network_config_mode_control_tb;
    import ncm_pkg::*;
    localparam logic [31:0] HOLD = 32'h40;
    localparam logic [31:0] DHCP = 32'hC8;
    logic mclk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic cfgSwitch = 1'b1, wantHost = 1'b0, answerDhcp = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, regRdata, dhcpHostName;
    logic irq, hostsOpen, dhcpBound, dhcpRequest, connRefuse, normalRun;
    logic configMode, rebootReq, powerReadyRed, powerReadyYellow;
    int errors = 0, checksDone = 0, cycles = 0;
    // dut and network
    ncm_mode_ctrl #(.HOLD_CYCLES(HOLD), .DHCP_CYCLES(DHCP),
        .SLOW_HALF(32'h10), .FAST_HALF(32'h4)) dut (
        .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .irq(irq), .cfgSwitch(cfgSwitch), .hostsOpen(hostsOpen),
        .dhcpBound(dhcpBound), .dhcpRequest(dhcpRequest),
        .dhcpHostName(dhcpHostName), .connRefuse(connRefuse),
        .normalRun(normalRun), .configMode(configMode),
        .rebootReq(rebootReq), .powerReadyRed(powerReadyRed),
        .powerReadyYellow(powerReadyYellow));
    ncm_net_model net (.mclk(mclk), .rst(rst), .wantHost(wantHost),
        .answerDhcp(answerDhcp), .connRefuse(connRefuse),
        .dhcpRequest(dhcpRequest), .hostsOpen(hostsOpen),
        .dhcpBound(dhcpBound));
    // clock and hang guard
    always #25 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            errors++;
            $display("MISMATCH timeout expected end seen hang");
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude
    task automatic chk(input string what, input logic [31:0] e,
        input logic [31:0] g);
        checksDone++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic chkb(input string what, input logic e, input logic g);
        chk(what, {31'h0, e}, {31'h0, g});
    endtask : chkb
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    // register strobes
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rchk(input string what, input logic [7:0] a,
        input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
        @(posedge mclk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRead <= 1'b0;
        #1;
        chk(what, e, regRdata & m);
    endtask : rchk
    task automatic stat(input logic [2:0] e);
        rchk("state", 8'h1C, {29'h0, e}, 32'h7);
    endtask : stat
    initial
    begin
        cyc(10);
        @(posedge mclk) rst <= 1'b0;
        cyc(HOLD + 16);
        stat(ST_PORESTORE);
        chkb("red", 1'b1, powerReadyRed);
        rchk("irqStat", REG_IRQ_STAT, 32'h4, 32'h1F);
        chkb("irq", 1'b0, irq);
        wr(REG_IRQ_MASK, 32'h1F);
        cyc(2);
        chkb("irq", 1'b1, irq);
        wr(REG_IRQ_STAT, 32'h4);
        cyc(2);
        chkb("irq", 1'b0, irq);
        @(posedge mclk) cfgSwitch <= 1'b0;
        cyc(8);
        stat(ST_BOOT);
        chkb("dhcpRequest", 1'b1, dhcpRequest);
        chk("hostName", DEF_HOSTNAME, dhcpHostName);
        $display("restore done");
        cyc(90);
        chkb("configMode", 1'b0, configMode);
        for (int i = 0; i < 150 && configMode !== 1'b1; i++)
            cyc(1);
        chkb("configMode", 1'b1, configMode);
        rchk("irqStat", REG_IRQ_STAT, 32'h3, 32'h1F);
        chkb("connRefuse", 1'b1, connRefuse);
        chkb("normalRun", 1'b0, normalRun);
        $display("timeout done");
        wr(REG_IP, 32'h0A00_0001);
        wr(REG_MASK, 32'hFFFF_FF00);
        wr(REG_GATEWAY, 32'h0A00_00FE);
        wr(REG_DNS, 32'h0A00_0002);
        wr(REG_FLAGS, 32'h0);
        wr(REG_HOSTNAME, 32'h0000_1234);
        chkb("configMode", 1'b1, configMode);
        wr(REG_COMMIT, 32'h1);
        #1;
        chkb("rebootReq", 1'b1, rebootReq);
        cyc(8);
        stat(ST_NORMAL);
        rchk("ip", REG_IP, 32'h0A00_0001);
        rchk("dns", REG_DNS, 32'h0A00_0002);
        chk("hostName", 32'h0000_1234, dhcpHostName);
        chkb("yellow", 1'b1, powerReadyYellow);
        $display("commit done");
        wr(REG_IRQ_STAT, 32'h1F);
        wr(REG_IP, 32'hDEAD_0000);
        rchk("ip", REG_IP, 32'h0A00_0001);
        rchk("irqStat", REG_IRQ_STAT, 32'h10, 32'h1F);
        rchk("unmapped", 8'h40, 32'h0);
        $display("protect done");
        @(posedge mclk) wantHost <= 1'b1;
        @(posedge mclk) cfgSwitch <= 1'b1;
        cyc(HOLD + 12);
        stat(ST_NORMAL);
        chkb("yellow", 1'b1, powerReadyYellow);
        @(posedge mclk) cfgSwitch <= 1'b0;
        cyc(4);
        @(posedge mclk) wantHost <= 1'b0;
        cyc(4);
        $display("hosts done");
        @(posedge mclk) cfgSwitch <= 1'b1;
        cyc(HOLD / 2);
        stat(ST_HOLD);
        @(posedge mclk) cfgSwitch <= 1'b0;
        cyc(6);
        stat(ST_NORMAL);
        @(posedge mclk) cfgSwitch <= 1'b1;
        cyc(HOLD / 2 + 8);
        stat(ST_HOLD);
        cyc(HOLD / 2 + 4);
        stat(ST_ARMED);
        chkb("red", 1'b1, powerReadyRed);
        chkb("yellow", 1'b0, powerReadyYellow);
        @(posedge mclk) cfgSwitch <= 1'b0;
        cyc(6);
        chkb("configMode", 1'b1, configMode);
        $display("hold done");
        @(posedge mclk) rst <= 1'b1;
        cfgSwitch <= 1'b1;
        cyc(10);
        @(posedge mclk) rst <= 1'b0;
        cyc(HOLD / 2);
        @(posedge mclk) cfgSwitch <= 1'b0;
        cyc(8);
        stat(ST_BOOT);
        rchk("irqStat", REG_IRQ_STAT, 32'h0, 32'h1F);
        @(posedge mclk) answerDhcp <= 1'b1;
        cyc(8);
        chkb("normalRun", 1'b1, normalRun);
        $display("release done");
        conclude();
    end
endmodule : network_config_mode_control_tb
